// file: core/asrr_pkg.sv
// Summary of operation
// R1: results are 16-bit two's complement codes
// R2: no result before its conversion completes
// R3: internal clock: send result n during n+1
// R4: internal: data, clock low outside transmission
// R5: internal: 16 bits MSB first, both edges
// R6: busy stays low over internal transmission
// R7: external: host reads after, during, or both
// R8: external: rising edge starts, falling edge valid
// R9: rising-edge samplers need one extra clock
// R10: clock high at load keeps old result
// R11: shift register updates only at conversion end
// R12: host clocks between conversions, then holds static
// R13: reading during conversion needs at least 2MHz
// R14: chip select high disables outputs, gates clock
// R15: start ignores chip select level
// R16: chip select high: transmission runs, outputs off
// R17: clock pin output only in internal mode
// R18: host idles clock 5 us before busy rises
// R19: host inputs static 19 us after start
// R20: start only when idle, ignored while converting
// R21: load once per conversion, shift, no wrap
package asrr_pkg;

  // --------------------------------------------------------------
  // widths and timing
  // --------------------------------------------------------------
  localparam int ASRR_WORD_BITS = 16;
  localparam int ASRR_SYNC_STAGES = 3;
  localparam int ASRR_CLK_PERIOD_NS = 25;
  localparam int ASRR_SAMPLE_START_N_TIME_NS = 18000;
  localparam int ASRR_BUSY_DELAY_NS = 90;
  localparam int ASRR_FIRST_CLK_NS = 2000;
  localparam int ASRR_INT_HALF_NS = 410;
  localparam int ASRR_SAMPLE_START_N_PULSE_NS = 100;
  localparam int ASRR_HOST_HALF_NS = 250;
  localparam int ASRR_QUIET_BEFORE_BUSY_US = 5;
  localparam int ASRR_STATIC_AFTER_START_US = 19;

  localparam int ASRR_SAMPLE_START_N_CYC = (ASRR_SAMPLE_START_N_TIME_NS + ASRR_CLK_PERIOD_NS - 1) / ASRR_CLK_PERIOD_NS;
  localparam int ASRR_BUSY_CYC = (ASRR_BUSY_DELAY_NS + ASRR_CLK_PERIOD_NS - 1) / ASRR_CLK_PERIOD_NS;
  localparam int ASRR_FIRST_CLK_CYC = (ASRR_FIRST_CLK_NS + ASRR_CLK_PERIOD_NS - 1) / ASRR_CLK_PERIOD_NS;
  localparam int ASRR_INT_HALF_CYC = (ASRR_INT_HALF_NS + ASRR_CLK_PERIOD_NS - 1) / ASRR_CLK_PERIOD_NS;
  localparam int ASRR_INT_LEAD_CYC = ASRR_INT_HALF_CYC / 2;
  localparam int ASRR_SAMPLE_START_N_PULSE_CYC = (ASRR_SAMPLE_START_N_PULSE_NS + ASRR_CLK_PERIOD_NS - 1) / ASRR_CLK_PERIOD_NS;
  localparam int ASRR_HOST_HALF_CYC = ASRR_HOST_HALF_NS / ASRR_CLK_PERIOD_NS;

  // --------------------------------------------------------------
  // codes and levels
  // --------------------------------------------------------------
  localparam logic [15:0] ASRR_SHREG_RST = 16'h0000;
  localparam logic [15:0] ASRR_MSB_FLIP = 16'h8000;
  localparam logic ASRR_LO = 1'h0;
  localparam logic ASRR_HI = 1'h1;

  typedef enum logic [1:0] {ASRR_D_IDLE, ASRR_D_CONVERT, ASRR_D_FINISH} asrr_dev_phase_e;
  typedef enum logic [2:0] {ASRR_H_IDLE, ASRR_H_PULSE, ASRR_H_WAIT_LOW, ASRR_H_WAIT_HIGH,
                            ASRR_H_SHIFT} asrr_host_phase_e;

  // filtered level: changes once second and third stages agree
  function automatic logic asrr_filt(input logic [2:0] s, input logic lvl);
    asrr_filt = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

endpackage

// file: core/asrr_if.sv
`timescale 1ns/1ps
interface asrr_if;
  logic sample_start_n;
  logic chip_select_n;
  logic clock_source_select;
  logic data_o;
  logic data_oe;
  logic busy_n_o;
  logic busy_oe;
  logic sclk_dev_o;
  logic sclk_dev_oe;
  logic sclk_host_o;
  logic sclk_host_oe;
  logic data;
  logic busy_n;
  logic serial_shift_clock;

  // resolved wire levels; undriven data low, undriven busy high
  assign serial_shift_clock = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'h0);
  assign data = data_oe ? data_o : 1'h0;
  assign busy_n = busy_oe ? busy_n_o : 1'h1;

  modport device (
    input sample_start_n, chip_select_n, clock_source_select, serial_shift_clock,
    output data_o, data_oe, busy_n_o, busy_oe, sclk_dev_o, sclk_dev_oe
  );
  modport host (
    input data, busy_n, serial_shift_clock,
    output sample_start_n, chip_select_n, clock_source_select, sclk_host_o, sclk_host_oe
  );
endinterface

// file: core/asrr_device.sv
`timescale 1ns/1ps
module asrr_device import asrr_pkg::*; #(
  parameter int SAMPLE_START_N_CYC = ASRR_SAMPLE_START_N_CYC,
  parameter int BUSY_CYC = ASRR_BUSY_CYC,
  parameter int FIRST_CLK_CYC = ASRR_FIRST_CLK_CYC,
  parameter int INT_HALF_CYC = ASRR_INT_HALF_CYC,
  parameter int INT_LEAD_CYC = ASRR_INT_LEAD_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link pins
  asrr_if.device link,
  // working register from the converter core
  input wire logic [15:0] i_raw_code,
  // status
  output logic o_busy,
  output logic o_result_loaded,
  output logic o_load_skipped,
  output logic o_ext_mode
);

  localparam int INT_PERIOD_CYC = 2 * INT_HALF_CYC;

  typedef struct packed {
    logic [2:0] sample_start_n_sync;
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [2:0] css_sync;
    logic sample_start_n_lvl;
    logic sclk_lvl;
    logic cs_lvl;
    logic css_lvl;
    asrr_dev_phase_e phase;
    logic [15:0] cnt;
    logic [15:0] shreg;
    logic [4:0] bits_sent;
    logic tx_on;
    logic tx_started;
    logic [15:0] tx_cnt;
    logic data_q;
    logic sclk_q;
    logic busy_n;
    logic loaded;
    logic skipped;
  } asrr_dev_s;

  asrr_dev_s q;
  asrr_dev_s next_q;
  logic sample_start_n_fall;
  logic sclk_rise;
  logic cs_active;
  logic ext_mode;

  // one bit out at the top, zero fill from below
  function automatic logic [15:0] shift_out(input logic [15:0] v);
    shift_out = {v[14:0], ASRR_LO};
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.sample_start_n_sync = {q.sample_start_n_sync[1:0], link.sample_start_n};
    next_q.sclk_sync = {q.sclk_sync[1:0], link.serial_shift_clock};
    next_q.cs_sync = {q.cs_sync[1:0], link.chip_select_n};
    next_q.css_sync = {q.css_sync[1:0], link.clock_source_select};
    next_q.sample_start_n_lvl = asrr_filt(q.sample_start_n_sync, q.sample_start_n_lvl);
    next_q.sclk_lvl = asrr_filt(q.sclk_sync, q.sclk_lvl);
    next_q.cs_lvl = asrr_filt(q.cs_sync, q.cs_lvl);
    next_q.css_lvl = asrr_filt(q.css_sync, q.css_lvl);
    sample_start_n_fall = q.sample_start_n_lvl & ~next_q.sample_start_n_lvl;
    sclk_rise = ~q.sclk_lvl & next_q.sclk_lvl;
    cs_active = ~next_q.cs_lvl;
    // mode as filtered this cycle, in step with the start edge
    ext_mode = next_q.css_lvl;
    next_q.loaded = ASRR_LO;
    next_q.skipped = ASRR_LO;

    // ------------------------------------------------------------
    // external clock shifting
    // ------------------------------------------------------------
    if (ext_mode) begin
      next_q.sclk_q = ASRR_LO;
      if (sclk_rise && cs_active) begin // R14
        if (q.bits_sent < 5'(ASRR_WORD_BITS)) begin // R21
          next_q.data_q = q.shreg[ASRR_WORD_BITS-1]; // R8
          next_q.shreg = shift_out(q.shreg);
          next_q.bits_sent = q.bits_sent + 5'd1;
        end else begin
          next_q.data_q = ASRR_LO;
        end
      end
    end

    // ------------------------------------------------------------
    // internal clock transmission, runs regardless of chip select
    // ------------------------------------------------------------
    if (!ext_mode && q.tx_on) begin // R16
      if (!q.tx_started) begin
        next_q.tx_cnt = q.tx_cnt + 16'd1;
        if (q.tx_cnt == 16'(FIRST_CLK_CYC - INT_LEAD_CYC - 1)) begin
          next_q.tx_started = ASRR_HI;
          next_q.tx_cnt = '0;
        end
      end else begin
        next_q.tx_cnt = q.tx_cnt + 16'd1;
        if (q.tx_cnt == '0) begin
          next_q.data_q = q.shreg[ASRR_WORD_BITS-1]; // R5
          next_q.shreg = shift_out(q.shreg);
        end
        // clock high mid-bit so the bit is stable on both edges
        next_q.sclk_q = (q.tx_cnt >= 16'(INT_LEAD_CYC)) && (q.tx_cnt < 16'(INT_LEAD_CYC + INT_HALF_CYC)); // R5
        if (q.tx_cnt == 16'(INT_PERIOD_CYC - 1)) begin
          next_q.tx_cnt = '0;
          next_q.bits_sent = q.bits_sent + 5'd1;
          if (q.bits_sent == 5'(ASRR_WORD_BITS - 1)) begin
            next_q.tx_on = ASRR_LO; // R4
            next_q.data_q = ASRR_LO;
            next_q.sclk_q = ASRR_LO;
          end
        end
      end
    end else if (!ext_mode) begin
      next_q.data_q = ASRR_LO; // R4
      next_q.sclk_q = ASRR_LO;
    end

    // ------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------
    case (q.phase)
      ASRR_D_IDLE: begin
        if (sample_start_n_fall) begin // R15 R20
          next_q.phase = ASRR_D_CONVERT;
          next_q.cnt = '0;
          next_q.busy_n = ASRR_LO; // R6
          if (!ext_mode) begin
            next_q.tx_on = ASRR_HI; // R3
            next_q.tx_started = ASRR_LO;
            next_q.tx_cnt = '0;
            next_q.bits_sent = '0;
          end
        end
      end
      ASRR_D_CONVERT: begin
        next_q.cnt = q.cnt + 16'd1;
        if (q.cnt == 16'(SAMPLE_START_N_CYC - 1)) begin
          next_q.phase = ASRR_D_FINISH;
          next_q.cnt = '0;
          next_q.tx_on = ASRR_LO;
          next_q.data_q = ext_mode ? next_q.data_q : ASRR_LO;
          next_q.sclk_q = ASRR_LO;
          // clock high at load keeps the old word
          if (ext_mode && next_q.sclk_lvl && cs_active) begin
            next_q.skipped = ASRR_HI; // R10 R18
          end else begin
            next_q.shreg = i_raw_code ^ ASRR_MSB_FLIP; // R1 R2 R11
            next_q.bits_sent = '0; // R21
            next_q.loaded = ASRR_HI;
          end
        end
      end
      ASRR_D_FINISH: begin
        next_q.cnt = q.cnt + 16'd1;
        if (q.cnt == 16'(BUSY_CYC - 1)) begin
          next_q.phase = ASRR_D_IDLE;
          next_q.busy_n = ASRR_HI;
        end
      end
      default: begin
        next_q.phase = ASRR_D_IDLE;
      end
    endcase

    if (!i_rst_n) begin
      next_q = '0;
      next_q.sample_start_n_sync = '1;
      next_q.cs_sync = '1;
      next_q.sample_start_n_lvl = ASRR_HI;
      next_q.cs_lvl = ASRR_HI;
      next_q.busy_n = ASRR_HI;
      next_q.shreg = ASRR_SHREG_RST;
      next_q.bits_sent = 5'(ASRR_WORD_BITS);
      next_q.phase = ASRR_D_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    q <= next_q;
  end

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  assign link.data_o = q.data_q;
  assign link.data_oe = ~q.cs_lvl; // R14
  assign link.busy_n_o = q.busy_n;
  assign link.busy_oe = ~q.cs_lvl; // R14
  assign link.sclk_dev_o = q.sclk_q;
  assign link.sclk_dev_oe = ~q.css_lvl & ~q.cs_lvl; // R17 R14

  assign o_busy = ~q.busy_n;
  assign o_result_loaded = q.loaded;
  assign o_load_skipped = q.skipped;
  assign o_ext_mode = q.css_lvl;

endmodule

// file: core/asrr_host.sv
`timescale 1ns/1ps
module asrr_host import asrr_pkg::*; #(
  parameter int HALF_CYC = ASRR_HOST_HALF_CYC,
  parameter int PULSE_CYC = ASRR_SAMPLE_START_N_PULSE_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link pins
  asrr_if.host link,
  // user side
  input wire logic i_start,
  input wire logic i_ext_clock,
  input wire logic i_select,
  output logic o_ready,
  output logic [15:0] o_word,
  output logic o_word_valid
);

  typedef struct packed {
    asrr_host_phase_e phase;
    logic [15:0] cnt;
    logic sample_start_n_n;
    logic cs_n;
    logic ext;
    logic sclk_q;
    logic [4:0] bits;
    logic [15:0] word;
    logic valid;
    logic [2:0] busy_sync;
    logic [2:0] data_sync;
    logic [2:0] dclk_sync;
    logic busy_lvl;
    logic data_lvl;
    logic dclk_lvl;
  } asrr_host_s;

  asrr_host_s q;
  asrr_host_s next_q;
  logic dclk_fall;

  // one bit in at the bottom
  function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b);
    shift_in = {v[14:0], b};
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.busy_sync = {q.busy_sync[1:0], link.busy_n};
    next_q.data_sync = {q.data_sync[1:0], link.data};
    next_q.dclk_sync = {q.dclk_sync[1:0], link.serial_shift_clock};
    next_q.busy_lvl = asrr_filt(q.busy_sync, q.busy_lvl);
    next_q.data_lvl = asrr_filt(q.data_sync, q.data_lvl);
    next_q.dclk_lvl = asrr_filt(q.dclk_sync, q.dclk_lvl);
    dclk_fall = q.dclk_lvl & ~next_q.dclk_lvl;
    next_q.valid = ASRR_LO;
    next_q.cs_n = ~i_select;

    case (q.phase)
      ASRR_H_IDLE: begin
        next_q.ext = i_ext_clock;
        if (i_start) begin
          next_q.phase = ASRR_H_PULSE;
          next_q.sample_start_n_n = ASRR_LO;
          next_q.cnt = '0;
        end
      end
      ASRR_H_PULSE: begin
        next_q.cnt = q.cnt + 16'd1;
        if (q.cnt == 16'(PULSE_CYC - 1)) begin
          next_q.sample_start_n_n = ASRR_HI;
          next_q.phase = ASRR_H_WAIT_LOW;
        end
      end
      ASRR_H_WAIT_LOW: begin
        if (!next_q.busy_lvl) begin
          next_q.phase = ASRR_H_WAIT_HIGH;
          next_q.bits = '0;
        end
      end
      ASRR_H_WAIT_HIGH: begin
        // host clock held low through the conversion; internal-mode bits taken on device clock falls
        if (!q.ext && dclk_fall && q.bits < 5'(ASRR_WORD_BITS)) begin // R12 R19
          next_q.word = shift_in(q.word, next_q.data_lvl);
          next_q.bits = q.bits + 5'd1;
          next_q.valid = (q.bits == 5'(ASRR_WORD_BITS - 1));
        end
        if (next_q.busy_lvl) begin
          next_q.phase = q.ext ? ASRR_H_SHIFT : ASRR_H_IDLE; // R7
          next_q.cnt = '0;
          next_q.bits = '0;
        end
      end
      ASRR_H_SHIFT: begin
        next_q.cnt = q.cnt + 16'd1;
        if (q.cnt == 16'(HALF_CYC - 1)) begin // R13
          next_q.cnt = '0;
          next_q.sclk_q = ~q.sclk_q;
          if (q.sclk_q) begin // R9
            next_q.word = shift_in(q.word, next_q.data_lvl); // R8
            next_q.bits = q.bits + 5'd1;
            if (q.bits == 5'(ASRR_WORD_BITS - 1)) begin
              next_q.valid = ASRR_HI;
              next_q.phase = ASRR_H_IDLE;
            end
          end
        end
      end
      default: begin
        next_q.phase = ASRR_H_IDLE;
      end
    endcase

    if (!i_rst_n) begin
      next_q = '0;
      next_q.sample_start_n_n = ASRR_HI;
      next_q.cs_n = ASRR_HI;
      next_q.busy_sync = '1;
      next_q.busy_lvl = ASRR_HI;
      next_q.phase = ASRR_H_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    q <= next_q;
  end

  // --------------------------------------------------------------
  // pin and user drivers
  // --------------------------------------------------------------
  assign link.sample_start_n = q.sample_start_n_n;
  assign link.chip_select_n = q.cs_n;
  assign link.clock_source_select = q.ext;
  assign link.sclk_host_o = q.sclk_q;
  assign link.sclk_host_oe = q.ext;

  assign o_ready = (q.phase == ASRR_H_IDLE);
  assign o_word = q.word;
  assign o_word_valid = q.valid;

endmodule

// file: testbench/asrr_assertions.sv
`timescale 1ns/1ps
module asrr_assertions import asrr_pkg::*; #(
  parameter int SAMPLE_START_N_CYC = ASRR_SAMPLE_START_N_CYC,
  parameter int BUSY_CYC = ASRR_BUSY_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link signals
  input wire logic sample_start_n,
  input wire logic chip_select_n,
  input wire logic clock_source_select,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic busy_n_o,
  input wire logic busy_oe,
  input wire logic sclk_dev_o,
  input wire logic sclk_dev_oe,
  input wire logic serial_shift_clock
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  localparam int LO_MIN = SAMPLE_START_N_CYC + BUSY_CYC - 2;
  localparam int LO_MAX = SAMPLE_START_N_CYC + BUSY_CYC + 2;
  int lo_cnt;
  int edge_cnt;
  logic sclk_q;
  logic busy_q;

  // low-time of busy, and device clock rises per frame
  always_ff @(posedge i_clk_sys) begin
    sclk_q <= sclk_dev_o;
    busy_q <= busy_n_o;
    lo_cnt <= busy_n_o ? 0 : lo_cnt + 1;
    if (busy_q && !busy_n_o) begin
      edge_cnt <= 0;
    end else if (sclk_dev_o && !sclk_q) begin
      edge_cnt <= edge_cnt + 1;
    end
  end

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence start_seen;
    $fell(sample_start_n) && busy_n_o;
  endsequence
  sequence busy_release;
    busy_n_o && !busy_q;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_cs_disables_out: assert property (chip_select_n [*8] |-> !data_oe && !busy_oe && !sclk_dev_oe)
    else $error("outputs enabled while chip select is high");
  a_sclk_pin_dir: assert property (clock_source_select [*8] |-> !sclk_dev_oe)
    else $error("device drives clock pin in external mode");
  a_idle_lines_low: assert property (busy_n_o && sclk_dev_oe |-> !sclk_dev_o && !data_o)
    else $error("data or clock not low outside transmission");
  a_bit_hold_high: assert property (sclk_dev_o && $past(sclk_dev_o) |-> $stable(data_o))
    else $error("internal data changed while clock high");
  a_busy_span_len: assert property (busy_release |-> lo_cnt inside {[LO_MIN:LO_MAX]})
    else $error("busy low span has wrong length");
  a_start_gives_busy: assert property (start_seen |-> ##[2:8] !busy_n_o)
    else $error("start edge in idle did not raise busy");
  a_frame_sixteen: assert property (busy_release and !clock_source_select |-> edge_cnt == 16)
    else $error("internal frame did not carry sixteen clocks");
  a_ext_low_hold: assert property (clock_source_select && busy_n_o && busy_q && !serial_shift_clock
      && !$past(serial_shift_clock) |-> $stable(data_o))
    else $error("external data changed without a rising clock");
endmodule

// file: testbench/tb_adc_serial_result_readout.sv
`timescale 1ns/1ps
module tb_adc_serial_result_readout;
  logic i_clk_sys;
  logic i_rst_n;
  logic rst_host_n;
  logic [15:0] raw;
  logic start;
  logic ext;
  logic sel;
  logic ready;
  logic [15:0] word;
  logic word_valid;
  logic busy_dev;
  logic loaded;
  logic skipped;
  logic ext_dev;
  int fail_count;
  int compares;
  int loads;
  int skips;
  logic [15:0] raw_tab [4] = '{16'hffff, 16'h8000, 16'h7fff, 16'h0000};
  logic [15:0] exp_tab [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};

  // ------------------------------------------------------------
  // ends and checker
  // ------------------------------------------------------------
  asrr_if link_if();
  asrr_device asrr_device_inst(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(link_if), .i_raw_code(raw),
    .o_busy(busy_dev), .o_result_loaded(loaded), .o_load_skipped(skipped), .o_ext_mode(ext_dev));
  asrr_host asrr_host_inst(.i_clk_sys(i_clk_sys), .i_rst_n(rst_host_n), .link(link_if), .i_start(start),
    .i_ext_clock(ext), .i_select(sel), .o_ready(ready), .o_word(word), .o_word_valid(word_valid));
  asrr_assertions asrr_assertions_inst(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .sample_start_n(link_if.sample_start_n), .chip_select_n(link_if.chip_select_n),
    .clock_source_select(link_if.clock_source_select), .data_o(link_if.data_o), .data_oe(link_if.data_oe),
    .busy_n_o(link_if.busy_n_o), .busy_oe(link_if.busy_oe), .sclk_dev_o(link_if.sclk_dev_o),
    .sclk_dev_oe(link_if.sclk_dev_oe), .serial_shift_clock(link_if.serial_shift_clock));

  // load and skip pulses over the whole run
  always @(posedge i_clk_sys) begin
    if (loaded === 1'h1) begin
      loads++;
    end
    if (skipped === 1'h1) begin
      skips++;
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait: word_valid (k=0) or ready (k=1)
  task automatic wait_on(input bit k);
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while ((k ? ready : word_valid) !== 1'h1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      results();
    end
  endtask

  // one conversion with readout through the host
  task automatic convert(input logic mode, input logic [15:0] code, input logic [15:0] exp);
    raw <= code;
    ext <= mode;
    start <= 1'h1;
    @(posedge i_clk_sys);
    start <= 1'h0;
    wait_on(1'b0);
    check(word, exp);
    wait_on(1'b1);
    check({15'h0000, ext_dev}, {15'h0000, mode});
    check({15'h0000, busy_dev}, 16'h0000);
    @(posedge i_clk_sys);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    i_clk_sys = 1'h0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (40000) @(posedge i_clk_sys);
    fail_count++;
    results();
  end

  initial begin
    i_rst_n = 1'h0;
    rst_host_n = 1'h0;
    raw = 16'h0000;
    start = 1'h0;
    ext = 1'h0;
    sel = 1'h1;
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    rst_host_n <= 1'h1;
    repeat (8) @(posedge i_clk_sys);
    // internal clock: each frame carries the previous load
    convert(1'h0, raw_tab[0], 16'h0000);
    for (int i = 1; i < 4; i++) begin
      convert(1'h0, raw_tab[i], exp_tab[i - 1]);
    end
    // whole conversion with outputs off; host cannot see busy
    sel <= 1'h0;
    raw <= 16'h1234;
    start <= 1'h1;
    @(posedge i_clk_sys);
    start <= 1'h0;
    repeat (1000) @(posedge i_clk_sys);
    rst_host_n <= 1'h0;
    sel <= 1'h1;
    repeat (5) @(posedge i_clk_sys);
    rst_host_n <= 1'h1;
    repeat (8) @(posedge i_clk_sys);
    convert(1'h0, 16'h0000, 16'h9234);
    // external clock: read after each conversion, all code corners
    for (int i = 0; i < 4; i++) begin
      convert(1'h1, raw_tab[i], exp_tab[i]);
    end
    check(16'(loads), 16'd10);
    check(16'(skips), 16'd0);
    results();
  end
endmodule
